/* File: hw/dsia_defines.vh */
// Constants for the drive status input assembly block
`ifndef DSIA_DEFINES_VH
`define DSIA_DEFINES_VH

// Operation status word bit positions
`define DSIA_OSW_FWD 0
`define DSIA_OSW_REV 1
`define DSIA_OSW_ACC 9
`define DSIA_OSW_DEC 10
`define DSIA_OSW_ALM 11

// Byte 0 flag positions of the input words
`define DSIA_B0_FAULT 0
`define DSIA_B0_WARN 1
`define DSIA_B0_FWD 2
`define DSIA_B0_REV 3
`define DSIA_B0_READY 4
`define DSIA_B0_CTRL_NET 5
`define DSIA_B0_REF_NET 6
`define DSIA_B0_AT_SPEED 7

// Word indices in the assembly store
`define DSIA_IDX_SHORT 1'h0
`define DSIA_IDX_EXT 1'h1

// Supervisor drive states
`define DSIA_ST_READY 8'h03
`define DSIA_ST_ENABLED 8'h04
`define DSIA_ST_STOPPING 8'h05

// Conversion factor, frequency to RPM
`define DSIA_RPM_FACTOR 8'h78

// Reset values
`define DSIA_RST_WORD 32'h0000_0000
`define DSIA_RST_POLES 8'h00

// Boot count at which the pole count is taken; the boot phase lasts four cycles (covers the two sync stages)
`define DSIA_BOOT_CYCLES 2'h3

`endif

/* File: hw/dsia_divider.v */
// Sequential restoring divider for the speed conversion
`timescale 1ns/1ps
module dsia_divider #(
    parameter DW = 24,
    parameter VW = 8
) (
    input wire clk_sys, // System clock
    input wire rstn, // Asynchronous reset, active low
    input wire start, // Pulse: begin a division
    input wire [DW-1:0] dividend, // Numerator
    input wire [VW-1:0] divisor, // Denominator, nonzero
    output reg busy, // High while dividing
    output reg done, // Pulse: quotient valid
    output reg [DW-1:0] quotient // Result
);

    reg [VW:0] rem;
    reg [DW-1:0] num;
    reg [VW-1:0] den;
    reg [5:0] cnt;
    wire [VW:0] shifted;
    wire [VW:0] diff;

    // One quotient bit per cycle keeps the datapath small; latency is DW cycles
    assign shifted = {rem[VW-1:0], num[DW-1]};
    assign diff = shifted - {1'b0, den};

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            rem <= {(VW+1){1'b0}};
            num <= {DW{1'b0}};
            den <= {VW{1'b0}};
            cnt <= 6'h00;
            quotient <= {DW{1'b0}};
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                rem <= {(VW+1){1'b0}};
                num <= dividend;
                den <= divisor;
                cnt <= DW[5:0];
            end
            else if (busy)
            begin
                if (diff[VW])
                    rem <= shifted;
                else
                    rem <= diff;
                num <= {num[DW-2:0], ~diff[VW]};
                cnt <= cnt - 6'h01;
                if (cnt == 6'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= {num[DW-2:0], ~diff[VW]};
                end
            end
        end
    end

endmodule // dsia_divider

/* File: hw/dsia_asm_mem.v */
// Two-word store holding the assembled input words, registered read
`timescale 1ns/1ps
module dsia_asm_mem #(
    parameter AW = 1,
    parameter WW = 32
) (
    input wire clk_sys, // System clock
    input wire rstn, // Asynchronous reset, active low
    input wire wr_en, // Write strobe
    input wire [AW-1:0] wr_addr, // Write index
    input wire [WW-1:0] wr_data, // Write data
    input wire rd_en, // Read strobe
    input wire [AW-1:0] rd_addr, // Read index
    output reg [WW-1:0] rd_data // Read data, one cycle after rd_en
);

    reg [WW-1:0] mem [0:(1<<AW)-1];
    integer i;

    // Storage cleared at reset so the first read never shows stale data
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (i = 0; i < (1 << AW); i = i + 1)
                mem[i] <= {WW{1'b0}};
        end
        else if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rd_data <= {WW{1'b0}};
        else if (rd_en)
            rd_data <= mem[rd_addr];
    end

endmodule // dsia_asm_mem

/* File: hw/dsia_top.v */
// Drive status input assembly: packs inverter status into two input words
`timescale 1ns/1ps
`include "dsia_defines.vh"
module dsia_top #(
    parameter FW = 16,
    parameter PW = 8
) (
    input wire clk_sys, // System clock, 200 MHz
    input wire rstn, // Asynchronous reset, active low
    input wire [15:0] operation_status_word, // Inverter status word, async
    input wire [FW-1:0] output_frequency_code, // Output frequency in Hz, async
    input wire [PW-1:0] motor_pole_count_code, // Motor pole count setting, async
    input wire [7:0] drive_state, // Supervisor state, same clock
    input wire read_hold, // Controller is reading, freeze words
    input wire rd_en, // Read strobe from controller side
    input wire rd_sel, // 0 short word, 1 extended word
    output wire [31:0] rd_data, // Word read, from register
    output reg rd_valid, // Pulse: rd_data valid
    output reg [31:0] asm_short, // Short input word, live copy
    output reg [31:0] asm_ext, // Extended input word, live copy
    output reg [PW-1:0] pole_count, // Pole count captured at boot
    output reg boot_done // High once the pole count is taken
);

    localparam DW = FW + 8;

    // One-hot states
    localparam [3:0] S_BOOT = 4'h1;
    localparam [3:0] S_IDLE = 4'h2;
    localparam [3:0] S_DIV = 4'h4;
    localparam [3:0] S_STORE = 4'h8;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [1:0] boot_cnt;

    reg [15:0] osw_s1;
    reg [15:0] osw_s2;
    reg [FW-1:0] freq_s1;
    reg [FW-1:0] freq_s2;
    reg [PW-1:0] pole_s1;
    reg [PW-1:0] pole_s2;

    reg [15:0] osw_snap;
    reg [7:0] dstate_snap;
    reg [15:0] speed_rpm;
    reg div_start;
    reg store_short;

    wire div_busy;
    wire div_done;
    wire [DW-1:0] div_q;
    wire [DW-1:0] freq_x120;
    wire pole_zero;
    wire flag_fault;
    wire flag_fwd;
    wire flag_rev;
    wire flag_ready;
    wire flag_at_speed;
    wire [7:0] byte0_short;
    wire [7:0] byte0_ext;
    wire [31:0] word_short;
    wire [31:0] word_ext;
    wire mem_wr;
    wire [31:0] mem_wdata;
    wire [0:0] mem_waddr;

    // Ready only in the states where the drive can accept or is running a command
    function is_ready_state;
        input [7:0] st;
        begin
            is_ready_state = (st == `DSIA_ST_READY) || (st == `DSIA_ST_ENABLED)
                || (st == `DSIA_ST_STOPPING);
        end
    endfunction

    // Running either way with no ramp in progress
    function at_speed;
        input [15:0] osw;
        begin
            at_speed = (osw[`DSIA_OSW_FWD] || osw[`DSIA_OSW_REV])
                && !osw[`DSIA_OSW_ACC] && !osw[`DSIA_OSW_DEC];
        end
    endfunction

    // Status word synchroniser; only the second stage feeds the logic
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            osw_s1 <= 16'h0000;
            osw_s2 <= 16'h0000;
        end
        else
        begin
            osw_s1 <= operation_status_word;
            osw_s2 <= osw_s1;
        end
    end

    // Frequency synchroniser; a word torn by a change is replaced on the next loop
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            freq_s1 <= {FW{1'b0}};
            freq_s2 <= {FW{1'b0}};
        end
        else
        begin
            freq_s1 <= output_frequency_code;
            freq_s2 <= freq_s1;
        end
    end

    // Pole count synchroniser; its output is only looked at once, at boot
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pole_s1 <= {PW{1'b0}};
            pole_s2 <= {PW{1'b0}};
        end
        else
        begin
            pole_s1 <= motor_pole_count_code;
            pole_s2 <= pole_s1;
        end
    end

    // Boot phase: wait for the synchronisers to fill, then take the pole count once
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_cnt <= 2'h0;
            boot_done <= 1'b0;
            pole_count <= `DSIA_RST_POLES;
        end
        else if (!boot_done)
        begin
            boot_cnt <= boot_cnt + 2'h1;
            if (boot_cnt == `DSIA_BOOT_CYCLES)
            begin
                boot_done <= 1'b1;
                pole_count <= pole_s2;
            end
        end
    end

    // Frequency times 120; widened so the product never wraps
    assign freq_x120 = {8'h00, freq_s2} * {{(DW-8){1'b0}}, `DSIA_RPM_FACTOR};

    // A zero pole count has no meaningful speed; the divider is bypassed then
    assign pole_zero = (pole_count == {PW{1'b0}});

    // Sequencer: snapshot status, divide, then store both words
    always @*
    begin
        next_state = state;
        case (state)
            S_BOOT:
                if (boot_done)
                    next_state = S_IDLE;
            S_IDLE:
                // Wait out any division still running before launching another
                if (!div_busy)
                    next_state = S_DIV;
            S_DIV:
                if (div_done || pole_zero)
                    next_state = S_STORE;
            S_STORE:
                // Extended word goes first; leave once the short word is written
                if (!read_hold && store_short)
                    next_state = S_IDLE;
            default:
                next_state = S_BOOT;
        endcase
    end

    // State register
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            state <= S_BOOT;
        else
            state <= next_state;
    end

    // Snapshot and divider control
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            osw_snap <= 16'h0000;
            dstate_snap <= 8'h00;
            speed_rpm <= 16'h0000;
            div_start <= 1'b0;
        end
        else
        begin
            div_start <= 1'b0;
            if (state == S_IDLE)
            begin
                osw_snap <= osw_s2;
                dstate_snap <= drive_state;
                div_start <= !pole_zero;
            end
            // A zero pole count would divide by zero; report zero speed instead
            if (state == S_DIV && pole_zero)
                speed_rpm <= 16'h0000;
            else if (div_done && !pole_zero)
                speed_rpm <= div_q[15:0];
        end
    end

    // Divisor is fixed after boot, so it never changes under a running division
    dsia_divider #(
        .DW(DW),
        .VW(PW)
    ) u_div (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(div_start),
        .dividend(freq_x120),
        .divisor(pole_count),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q)
    );

    // Individual flags, each carried by one rule
    assign flag_fault = osw_snap[`DSIA_OSW_ALM];
    assign flag_fwd = osw_snap[`DSIA_OSW_FWD];
    assign flag_rev = osw_snap[`DSIA_OSW_REV];
    assign flag_ready = is_ready_state(dstate_snap);
    assign flag_at_speed = at_speed(osw_snap);

    // Byte 0 of the extended word, one flag per position
    assign byte0_ext[`DSIA_B0_FAULT] = flag_fault;
    assign byte0_ext[`DSIA_B0_WARN] = 1'b0;
    assign byte0_ext[`DSIA_B0_FWD] = flag_fwd;
    assign byte0_ext[`DSIA_B0_REV] = flag_rev;
    assign byte0_ext[`DSIA_B0_READY] = flag_ready;
    assign byte0_ext[`DSIA_B0_CTRL_NET] = 1'b0;
    assign byte0_ext[`DSIA_B0_REF_NET] = 1'b0;
    assign byte0_ext[`DSIA_B0_AT_SPEED] = flag_at_speed;

    // Short word keeps only fault and forward; masking keeps both words in step
    localparam [7:0] SHORT_MASK = (8'h01 << `DSIA_B0_FAULT) | (8'h01 << `DSIA_B0_FWD);
    assign byte0_short = byte0_ext & SHORT_MASK;

    // Full words, speed low byte in byte 2, high byte in byte 3
    assign word_short = {speed_rpm, 8'h00, byte0_short};
    assign word_ext = {speed_rpm, dstate_snap, byte0_ext};

    // Store takes two cycles, extended then short; held off while the controller reads
    assign mem_wr = (state == S_STORE) && !read_hold;
    assign mem_waddr = store_short ? `DSIA_IDX_SHORT : `DSIA_IDX_EXT;
    assign mem_wdata = store_short ? word_short : word_ext;

    // Selects which word the next store cycle writes
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            store_short <= 1'b0;
        else if (mem_wr)
            store_short <= ~store_short;
    end

    // Two-word store; reads stay open even while stores are held off
    dsia_asm_mem #(
        .AW(1),
        .WW(32)
    ) u_mem (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_en(rd_en),
        .rd_addr(rd_sel),
        .rd_data(rd_data)
    );

    // Live copies follow the store, so they too stay frozen during a read
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            asm_short <= `DSIA_RST_WORD;
            asm_ext <= `DSIA_RST_WORD;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (mem_wr && store_short)
                asm_short <= word_short;
            if (mem_wr && !store_short)
                asm_ext <= word_ext;
        end
    end

endmodule // dsia_top

/* File: tb/dsia_top_checker.sv */
// Port-level assertions for the drive status input assembly
`timescale 1ns/1ps
module dsia_top_checker #(
    parameter PW = 8
) (
    input wire clk_sys, // System clock
    input wire rstn, // Reset, active low
    input wire read_hold, // Freeze request
    input wire rd_en, // Read strobe
    input wire rd_sel, // Word select
    input wire [31:0] rd_data, // Read word
    input wire rd_valid, // Read answer strobe
    input wire [31:0] asm_short, // Short word copy
    input wire [31:0] asm_ext, // Extended word copy
    input wire [PW-1:0] pole_count, // Captured pole count
    input wire boot_done // Boot capture taken
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Word layout relations hold at every edge, also the all-zero reset words
    chk_quiet_flags: assert property (asm_ext[6:5] == 2'b00 && !asm_ext[1])
        else $error("unused flag set");
    chk_ready_state: assert property (
        asm_ext[4] == (asm_ext[15:8] >= 8'h03 && asm_ext[15:8] <= 8'h05))
        else $error("ready flag disagrees with state");
    chk_speed_running: assert property (asm_ext[7] |-> (asm_ext[2] || asm_ext[3]))
        else $error("up to speed while stopped");
    chk_short_layout: assert property (
        asm_short[15:8] == 8'h00 && asm_short[7:3] == 5'h00 && !asm_short[1])
        else $error("short word spare bits set");
    // Read answer comes exactly one cycle after the strobe
    chk_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    chk_valid_cause: assert property (!rd_en |=> !rd_valid)
        else $error("answer without strobe");
    // Three held cycles let any store already launched settle first
    chk_hold_frozen: assert property (
        read_hold [*3] |-> $stable(asm_ext) && $stable(asm_short))
        else $error("words changed while held");
    chk_hold_read: assert property (
        read_hold [*3] ##0 (rd_en && !rd_sel) |=> rd_data == $past(asm_short))
        else $error("held read differs from short word");
    chk_pole_fixed: assert property (
        boot_done && $past(boot_done) |-> $stable(pole_count))
        else $error("pole count changed after boot");

    cover property (rd_en && rd_sel);
    cover property (read_hold [*3] ##1 !read_hold);
    cover property ($rose(boot_done));
endmodule // dsia_top_checker

bind dsia_top dsia_top_checker #(.PW(PW)) chk (.clk_sys(clk_sys), .rstn(rstn),
    .read_hold(read_hold), .rd_en(rd_en), .rd_sel(rd_sel), .rd_data(rd_data),
    .rd_valid(rd_valid), .asm_short(asm_short), .asm_ext(asm_ext),
    .pole_count(pole_count), .boot_done(boot_done));

/* File: tb/dsia_ctl_model.sv */
// Network controller model that reads the input words
`timescale 1ns/1ps
module dsia_ctl_model (
    input wire clk_sys, // System clock
    input wire rd_valid, // Read answer strobe
    input wire [31:0] rd_data, // Read answer word
    output logic read_hold = 1'b0, // Freeze request
    output logic rd_en = 1'b0, // Read strobe
    output logic rd_sel = 1'b0 // Word select
);
    int slow = 0; // Idle cycles before each read, added to the one always waited

    // One read; a missing answer returns the inverted word so it cannot pass
    task read_word(input logic sel, output logic [31:0] d);
        repeat (slow + 1) @(posedge clk_sys);
        rd_en <= 1'b1;
        rd_sel <= sel;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        rd_sel <= ~sel;
        #1;
        d = (rd_valid === 1'b1) ? rd_data : ~rd_data;
    endtask

    task set_hold(input logic h);
        @(posedge clk_sys);
        read_hold <= h;
    endtask
endmodule // dsia_ctl_model

/* File: tb/dsia_top_tb.sv */
// Testbench for the drive status input assembly
`timescale 1ns/1ps
module dsia_top_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] osw = 16'h0000;
    logic [15:0] freq = 16'h0000;
    logic [7:0] poles = 8'h04;
    logic [7:0] dstate = 8'h00;
    wire read_hold, rd_en, rd_sel, rd_valid, boot_done;
    wire [31:0] rd_data, asm_short, asm_ext;
    wire [7:0] pole_count;
    logic [31:0] got, held, held_s;
    int failures = 0;
    int cmp_count = 0;
    logic [15:0] ot [6] = '{16'h0801, 16'h0002, 16'h0201, 16'h0402, 16'hf1fc, 16'h0003};
    logic [15:0] ft [6] = '{16'h0032, 16'h003c, 16'h0007, 16'h0001, 16'hffff, 16'h0000};
    logic [7:0] st [6] = '{8'h03, 8'h04, 8'h05, 8'h02, 8'h06, 8'hff};

    always #2.5 clk_sys = ~clk_sys;

    dsia_top uut (.clk_sys(clk_sys), .rstn(rstn), .operation_status_word(osw),
        .output_frequency_code(freq), .motor_pole_count_code(poles), .drive_state(dstate),
        .read_hold(read_hold), .rd_en(rd_en), .rd_sel(rd_sel), .rd_data(rd_data),
        .rd_valid(rd_valid), .asm_short(asm_short), .asm_ext(asm_ext),
        .pole_count(pole_count), .boot_done(boot_done));
    dsia_ctl_model ctl (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
        .read_hold(read_hold), .rd_en(rd_en), .rd_sel(rd_sel));

    task check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // Expected word from the current stimulus and the pole count in force
    function logic [31:0] expect_word(input logic ext, input logic [7:0] p);
        logic [15:0] spd;
        logic [7:0] b0;
        spd = (p == 8'h00) ? 16'h0000 : 16'((32'(freq) * 32'h78) / 32'(p));
        b0 = {ext & (osw[0] | osw[1]) & ~osw[9] & ~osw[10], 2'b00,
            ext & (dstate >= 8'h03 && dstate <= 8'h05), ext & osw[1], osw[0], 1'b0, osw[11]};
        return {spd, ext ? dstate : 8'h00, b0};
    endfunction

    // The store loop takes about 29 cycles; 70 covers a loop already under way
    task step(input logic [15:0] o, input logic [15:0] f, input logic [7:0] s);
        @(posedge clk_sys);
        osw <= o;
        freq <= f;
        dstate <= s;
        repeat (70) @(posedge clk_sys);
    endtask
    task verify(input logic [7:0] p);
        ctl.read_word(1'b0, got);
        check(got, expect_word(1'b0, p));
        ctl.read_word(1'b1, got);
        check(got, expect_word(1'b1, p));
    endtask
    task do_reset;
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        do_reset;
        check({24'h0, pole_count}, 32'h4);
        check({31'h0, boot_done}, 32'h1);
        $display("test boot done");
        for (int i = 0; i < 6; i++)
        begin
            step(ot[i], ft[i], st[i]);
            verify(8'h04);
        end
        $display("test flags done");
        held = expect_word(1'b1, 8'h04);
        held_s = expect_word(1'b0, 8'h04);
        ctl.slow = 3;
        ctl.set_hold(1'b1);
        step(16'h0801, 16'h000a, 8'h04);
        ctl.read_word(1'b1, got);
        check(got, held);
        ctl.read_word(1'b0, got);
        check(got, held_s);
        ctl.set_hold(1'b0);
        ctl.slow = 0;
        repeat (70) @(posedge clk_sys);
        verify(8'h04);
        $display("test hold done");
        poles <= 8'h02;
        step(16'h0001, 16'h0032, 8'h04);
        verify(8'h04);
        check({24'h0, pole_count}, 32'h4);
        do_reset;
        check({24'h0, pole_count}, 32'h2);
        step(16'h0001, 16'h0032, 8'h04);
        verify(8'h02);
        $display("test reboot done");
        final_report;
    end

    // Tests need about 780 cycles
    initial
    begin
        #100000;
        failures++;
        final_report;
    end
endmodule // dsia_top_tb
